//--- common/energy_pulse_map.svh
// constants for the energy pulse back end
// assumes one 100 MHz clock
`ifndef ENERGY_PULSE_MAP_SVH
`define ENERGY_PULSE_MAP_SVH
`define CLK_HZ 100000000
`define SAMPLE_HZ 4000
`define CONV_KHZ 4096
`define CLK_KHZ 100000
`define PULSE_FIXED_MS 80
`define PULSE_WIDTH_CLKS 6
`define POWER_READ_SHIFT 13
`define ENERGY_LOW_BITS 13
`define SEL_ACTIVE 3'h0
`define SEL_REACTIVE 3'h1
`define SEL_APPARENT 3'h2
`endif

//--- common/energy_pulse_pkg.sv
// types shared by the energy pulse back end and its pulse channels
// assumes energy_pulse_map.svh holds every numeric constant
package energy_pulse_pkg;
  typedef struct packed {
    logic signed [31:0] active;
    logic signed [31:0] reactive;
    logic signed [31:0] apparent;
  } power_samples_type;

  typedef struct packed {
    logic [2:0] type_sel;
    logic [2:0] term_sel;
    logic [15:0] divider;
    logic width_source;
    logic disable_out;
  } pulse_config_type;

  typedef struct packed {
    logic pulse_ready_one;
    logic pulse_ready_two;
    logic pulse_sign_change_one;
    logic pulse_sign_change_two;
    logic active_power_sign_change;
    logic reactive_power_sign_change;
  } status_type;
endpackage

//--- rtl/pulse_channel.sv
// one energy-to-frequency pulse channel
// assumes steady config, conv_en one-cycle strobe
`include "energy_pulse_map.svh"
module pulse_channel #(
  parameter int FIXED_CYCLES = 8000000
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic conv_en, // conversion-rate strobe
  input wire logic clear, // accumulator clear pulse
  input wire logic no_load, // selected energy in no load
  input wire logic signed [31:0] power, // selected power value
  input wire logic [31:0] threshold, // pulse threshold
  input wire logic [18:0] width_timer, // programmed width
  input wire energy_pulse_pkg::pulse_config_type cfg, // channel config
  output logic pulse_n, // active-low pulse pin
  output logic ready, // new pulse, one cycle
  output logic sign, // sign of latest pulse
  output logic sign_change // sign flipped, one cycle
);
  logic signed [43:0] acc_reg;
  logic signed [43:0] sum_next;
  logic signed [43:0] limit;
  logic raw_up, raw_dn, raw, term;
  logic [15:0] div_cnt_reg;
  logic signed [16:0] net_reg;
  logic signed [16:0] net_next;
  logic seen_reg, low_reg;
  logic [23:0] wcnt_reg;
  logic [15:0] hcnt_reg;
  logic [15:0] half;
  logic [21:0] timed_width;
  logic low_done;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    limit = {3'b000, threshold, 9'h000};
    sum_next = acc_reg + 44'(power);
    raw_up = conv_en && !no_load && (sum_next >= limit);
    raw_dn = conv_en && !no_load && (sum_next <= -limit);
    raw = raw_up || raw_dn;
    net_next = net_reg + (raw_up ? 17'sd1 : (raw_dn ? -17'sd1 : 17'sd0));
    term = raw && (17'(div_cnt_reg) + 17'h1 >= 17'(cfg.divider));
    // odd divider rounds the low half up, giving (1+1/div)x50%
    half = 16'((17'(cfg.divider) + 17'h1) >> 1);
    timed_width = 22'(width_timer) * 22'(`PULSE_WIDTH_CLKS);
    if (cfg.width_source) begin
      low_done = !no_load && (22'(wcnt_reg) + 22'h1 >= timed_width);
    end else begin
      low_done = (24'(wcnt_reg) + 24'h1 >= 24'(FIXED_CYCLES))
        || (raw && hcnt_reg + 16'h1 >= half);
    end
  end

  // converter: one raw pulse per threshold x 512 of energy
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      acc_reg <= 44'sh0;
    end else if (conv_en && !no_load) begin
      if (raw_up) begin
        acc_reg <= sum_next - limit;
      end else if (raw_dn) begin
        acc_reg <= sum_next + limit;
      end else begin
        acc_reg <= sum_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      div_cnt_reg <= 16'h0;
      net_reg <= 17'sh0;
    end else if (term) begin
      div_cnt_reg <= 16'h0;
      net_reg <= 17'sh0;
    end else if (raw) begin
      div_cnt_reg <= div_cnt_reg + 16'h1;
      net_reg <= net_next;
    end
  end

  // sign tracking ignores disable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sign <= 1'b0;
      sign_change <= 1'b0;
      seen_reg <= 1'b0;
      ready <= 1'b0;
    end else begin
      sign_change <= 1'b0;
      ready <= term && !cfg.disable_out;
      if (term) begin
        sign <= net_next < 0;
        seen_reg <= 1'b1;
        sign_change <= seen_reg && (sign != (net_next < 0));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_reg <= 1'b0;
      wcnt_reg <= 24'h0;
      hcnt_reg <= 16'h0;
    end else if (term) begin
      low_reg <= 1'b1;
      wcnt_reg <= 24'h0;
      hcnt_reg <= 16'h0;
    end else if (low_reg) begin
      if (low_done) begin
        low_reg <= 1'b0;
      end
      // held width freezes its timer through no load
      if (!(cfg.width_source && no_load)) begin
        wcnt_reg <= wcnt_reg + 24'h1;
      end
      if (raw) begin
        hcnt_reg <= hcnt_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_n <= 1'b1;
    end else begin
      pulse_n <= !(low_reg && !cfg.disable_out);
    end
  end
endmodule

//--- rtl/energy_pulse_and_power_accum.sv
// energy register update, two pulse outputs and power interval accumulation
// assumes all inputs come from logic on clk; only rstn is asynchronous
`include "energy_pulse_map.svh"
module energy_pulse_and_power_accum #(
  parameter int SAMPLE_DIV = `CLK_HZ / `SAMPLE_HZ,
  parameter int FIXED_CYCLES = `PULSE_FIXED_MS * `CLK_KHZ
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rstn, // async reset, active low
  input wire energy_pulse_pkg::power_samples_type samples, // power values
  input wire logic [2:0] no_load, // active, reactive, apparent no load
  input wire logic half_cycle, // half line cycle pulse
  input wire logic energy_overwrite_select, // load instead of add
  input wire logic energy_interval_source, // 1 counts half cycles
  input wire logic read_clear_enable, // clear high word on read
  input wire logic energy_power_enable, // accumulation on
  input wire logic [12:0] energy_interval_count, // energy interval minus one
  input wire logic [12:0] power_interval_count, // power interval minus one
  input wire logic energy_high_read, // high word read strobe
  input wire logic [31:0] pulse_threshold, // converter threshold
  input wire logic [18:0] pulse_width_timer, // width in six-clock units
  input wire energy_pulse_pkg::pulse_config_type cfg_one, // output one config
  input wire energy_pulse_pkg::pulse_config_type cfg_two, // output two config
  input wire logic pulse_accum_clear, // clear converter, one cycle
  input wire energy_pulse_pkg::status_type status_clear, // write-one-to-clear
  output logic pulse_output_one_n, // pulse pin one
  output logic pulse_output_two_n, // pulse pin two
  output logic [31:0] energy_high_word, // user energy upper bits
  output logic [12:0] energy_low_word, // user energy lower bits
  output logic energy_ready, // energy update, one cycle
  output logic power_ready, // power update, one cycle
  output logic [31:0] active_power_accum, // active accumulation
  output logic [31:0] reactive_power_accum, // reactive accumulation
  output logic [31:0] apparent_power_accum, // apparent accumulation
  output logic active_power_sign, // active accumulation negative
  output logic reactive_power_sign, // reactive accumulation negative
  output logic pulse_sign_one, // sign of last pulse one
  output logic pulse_sign_two, // sign of last pulse two
  output energy_pulse_pkg::status_type status // sticky flags
);
  localparam int CNT_W = $clog2(SAMPLE_DIV + 1);
  localparam logic [16:0] CONV_STEP = 17'(`CONV_KHZ);
  localparam logic [16:0] CONV_WRAP = 17'(`CLK_KHZ);

  if (SAMPLE_DIV < 2) begin : g_bad_div
    $error("SAMPLE_DIV must be at least 2");
  end
  if (FIXED_CYCLES < 1 || FIXED_CYCLES >= (1 << 24)) begin : g_bad_fixed
    $error("FIXED_CYCLES out of range");
  end

  logic rst_meta, rst_n;
  logic [CNT_W-1:0] sample_cnt_reg;
  logic sample_en;
  logic [16:0] phase_reg;
  logic conv_en;
  logic clear_pending;
  logic signed [41:0] energy_sum_reg;
  logic signed [44:0] user_energy_reg;
  logic signed [44:0] user_base;
  logic [12:0] energy_cnt_reg;
  logic energy_tick, energy_due;
  logic [12:0] power_cnt_reg;
  logic power_due;
  logic signed [41:0] pacc [3];
  logic signed [31:0] pwr_in [3];
  logic signed [31:0] pwr_one, pwr_two;
  logic nl_one, nl_two;
  logic rdy_one, rdy_two, chg_one, chg_two;
  logic new_active_sign, new_reactive_sign;
  logic seen_power_reg;

  ////////////////////////////////////////////////////////////////////////
  // two-flop reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // 4 kSPS strobe from an integer divider
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_cnt_reg <= '0;
    end else if (sample_en) begin
      sample_cnt_reg <= '0;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + CNT_W'(1);
    end
  end
  assign sample_en = (sample_cnt_reg == CNT_W'(SAMPLE_DIV - 1));

  // 4.096 MHz is no integer ratio of clk:
  // a phase accumulator, one cycle of jitter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= 17'h0;
    end else if (conv_en) begin
      phase_reg <= phase_reg + CONV_STEP - CONV_WRAP;
    end else begin
      phase_reg <= phase_reg + CONV_STEP;
    end
  end
  assign conv_en = (phase_reg + CONV_STEP >= CONV_WRAP);

  // one-cycle clear returns to zero by itself
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clear_pending <= 1'b0;
    end else begin
      clear_pending <= pulse_accum_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // energy interval and user energy register
  assign energy_tick = energy_interval_source ? half_cycle : sample_en;
  assign energy_due = energy_power_enable && energy_tick
    && (energy_cnt_reg == energy_interval_count);

  always_ff @(posedge clk) begin
    if (!rst_n || !energy_power_enable) begin
      energy_cnt_reg <= 13'h0;
    end else if (energy_due) begin
      energy_cnt_reg <= 13'h0;
    end else if (energy_tick) begin
      energy_cnt_reg <= energy_cnt_reg + 13'h1;
    end
  end

  // samples landing on the ready edge start the new interval
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      energy_sum_reg <= 42'sh0;
    end else if (energy_due) begin
      energy_sum_reg <= (sample_en && !no_load[0]) ? 42'(samples.active) : 42'sh0;
    end else if (energy_power_enable && sample_en && !no_load[0]) begin
      energy_sum_reg <= energy_sum_reg + 42'(samples.active);
    end
  end

  // read clears before an update adds
  always_comb begin
    user_base = user_energy_reg;
    if (energy_high_read && read_clear_enable) begin
      user_base[44:`ENERGY_LOW_BITS] = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      user_energy_reg <= 45'sh0;
    end else if (energy_due) begin
      if (energy_overwrite_select) begin
        user_energy_reg <= 45'(energy_sum_reg);
      end else begin
        user_energy_reg <= user_base + 45'(energy_sum_reg);
      end
    end else begin
      user_energy_reg <= user_base;
    end
  end
  assign energy_high_word = user_energy_reg[44:`ENERGY_LOW_BITS];
  assign energy_low_word = user_energy_reg[`ENERGY_LOW_BITS-1:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      energy_ready <= 1'b0;
      power_ready <= 1'b0;
    end else begin
      energy_ready <= energy_due;
      power_ready <= power_due;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power interval accumulation, no load does not stop it
  assign pwr_in[0] = samples.active;
  assign pwr_in[1] = samples.reactive;
  assign pwr_in[2] = samples.apparent;
  assign power_due = energy_power_enable && sample_en
    && (power_cnt_reg == power_interval_count);

  always_ff @(posedge clk) begin
    if (!rst_n || !energy_power_enable) begin
      power_cnt_reg <= 13'h0;
    end else if (power_due) begin
      power_cnt_reg <= 13'h0;
    end else if (sample_en) begin
      power_cnt_reg <= power_cnt_reg + 13'h1;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_pacc
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pacc[i] <= 42'sh0;
      end else if (power_due) begin
        pacc[i] <= 42'sh0;
      end else if (energy_power_enable && sample_en) begin
        pacc[i] <= pacc[i] + 42'(pwr_in[i]);
      end
    end
  end

  // final sample joins the interval it closes
  logic signed [41:0] pfinal [3];
  for (genvar i = 0; i < 3; i++) begin : g_pfinal
    assign pfinal[i] = pacc[i] + 42'(pwr_in[i]);
  end
  assign new_active_sign = pfinal[0][41];
  assign new_reactive_sign = pfinal[1][41];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_power_accum <= 32'h0;
      reactive_power_accum <= 32'h0;
      apparent_power_accum <= 32'h0;
      active_power_sign <= 1'b0;
      reactive_power_sign <= 1'b0;
      seen_power_reg <= 1'b0;
    end else if (power_due) begin
      active_power_accum <= 32'(pfinal[0] >>> `POWER_READ_SHIFT);
      reactive_power_accum <= 32'(pfinal[1] >>> `POWER_READ_SHIFT);
      apparent_power_accum <= 32'(pfinal[2] >>> `POWER_READ_SHIFT);
      active_power_sign <= new_active_sign;
      reactive_power_sign <= new_reactive_sign;
      seen_power_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse channels: type and term selection
  function automatic logic signed [31:0] pick(
    input logic [2:0] sel, input logic [2:0] terms,
    input energy_pulse_pkg::power_samples_type s);
    logic signed [31:0] v;
    v = 32'sh0;
    case (sel)
      `SEL_ACTIVE: v = s.active;
      `SEL_REACTIVE: v = s.reactive;
      `SEL_APPARENT: v = s.apparent;
      default: v = 32'sh0;
    endcase
    // single phase: only the first term bit contributes
    return terms[0] ? v : 32'sh0;
  endfunction

  function automatic logic pick_nl(input logic [2:0] sel, input logic [2:0] nl);
    case (sel)
      `SEL_ACTIVE: return nl[0];
      `SEL_REACTIVE: return nl[1];
      `SEL_APPARENT: return nl[2];
      default: return 1'b0;
    endcase
  endfunction

  assign pwr_one = pick(cfg_one.type_sel, cfg_one.term_sel, samples);
  assign pwr_two = pick(cfg_two.type_sel, cfg_two.term_sel, samples);
  assign nl_one = pick_nl(cfg_one.type_sel, no_load);
  assign nl_two = pick_nl(cfg_two.type_sel, no_load);

  pulse_channel #(.FIXED_CYCLES(FIXED_CYCLES)) u_pulse_one (
    .clk(clk),
    .rst_n(rst_n),
    .conv_en(conv_en),
    .clear(clear_pending),
    .no_load(nl_one),
    .power(pwr_one),
    .threshold(pulse_threshold),
    .width_timer(pulse_width_timer),
    .cfg(cfg_one),
    .pulse_n(pulse_output_one_n),
    .ready(rdy_one),
    .sign(pulse_sign_one),
    .sign_change(chg_one)
  );

  pulse_channel #(.FIXED_CYCLES(FIXED_CYCLES)) u_pulse_two (
    .clk(clk),
    .rst_n(rst_n),
    .conv_en(conv_en),
    .clear(clear_pending),
    .no_load(nl_two),
    .power(pwr_two),
    .threshold(pulse_threshold),
    .width_timer(pulse_width_timer),
    .cfg(cfg_two),
    .pulse_n(pulse_output_two_n),
    .ready(rdy_two),
    .sign(pulse_sign_two),
    .sign_change(chg_two)
  );

  ////////////////////////////////////////////////////////////////////////
  // sticky flags: a set in the clearing cycle wins
  energy_pulse_pkg::status_type set_ev;
  always_comb begin
    set_ev.pulse_ready_one = rdy_one;
    set_ev.pulse_ready_two = rdy_two;
    set_ev.pulse_sign_change_one = chg_one;
    set_ev.pulse_sign_change_two = chg_two;
    set_ev.active_power_sign_change = power_due && seen_power_reg
      && (new_active_sign != active_power_sign);
    set_ev.reactive_power_sign_change = power_due && seen_power_reg
      && (new_reactive_sign != reactive_power_sign);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= set_ev | (status & ~status_clear);
    end
  end
endmodule

//--- bench/energy_pulse_checker_asserts.sv
// assertions on the back end's ports
// assumes binding onto the top module
module energy_pulse_checker #(
  parameter int SAMPLE_DIV = 25000
) (
  input wire logic clk, // clock
  input wire logic rstn, // async reset
  input wire logic energy_power_enable, // accumulation on
  input wire logic [12:0] power_interval_count, // power interval
  input wire logic energy_high_read, // read strobe
  input wire logic read_clear_enable, // clear on read
  input wire logic [18:0] pulse_width_timer, // width setting
  input wire energy_pulse_pkg::pulse_config_type cfg_one, // output one config
  input wire logic [2:0] no_load, // no load levels
  input wire logic pulse_output_one_n, // pin one
  input wire logic [31:0] energy_high_word, // high word
  input wire logic [12:0] energy_low_word, // low word
  input wire logic energy_ready, // energy strobe
  input wire logic power_ready, // power strobe
  input wire logic [31:0] active_power_accum, // active sum
  input wire logic [31:0] reactive_power_accum, // reactive sum
  input wire logic active_power_sign, // active sign
  input wire logic reactive_power_sign, // reactive sign
  input wire energy_pulse_pkg::status_type status // sticky flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_cnt, low_cnt;
  logic gap_valid;
  logic [12:0] interval_q;
  // gap trusted only if the interval never moved
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_cnt <= 32'h0;
      gap_valid <= 1'b0;
      interval_q <= 13'h0;
    end else begin
      interval_q <= power_interval_count;
      gap_cnt <= power_ready ? 32'h1 : gap_cnt + 32'h1;
      gap_valid <= power_ready |
        (gap_valid & energy_power_enable & (power_interval_count == interval_q));
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= pulse_output_one_n ? 32'h0 : low_cnt + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_energy_ready_single: assert property (energy_ready |=> !energy_ready)
    else $error("energy ready too long");
  a_power_gap_length: assert property (power_ready && gap_valid |->
    gap_cnt == (32'(power_interval_count) + 32'h1) * SAMPLE_DIV)
    else $error("power interval wrong");
  a_power_accum_hold: assert property (!power_ready |->
    $stable(active_power_accum) && $stable(reactive_power_accum))
    else $error("power moved early");
  a_power_sign_follow: assert property (power_ready |->
    active_power_sign == active_power_accum[31] &&
    reactive_power_sign == reactive_power_accum[31])
    else $error("power sign wrong");
  a_power_sign_flag: assert property (
    power_ready && active_power_sign != $past(active_power_sign) |->
    ##[0:1] status.active_power_sign_change)
    else $error("sign change missed");
  a_disable_pin_high: assert property (
    cfg_one.disable_out && $past(cfg_one.disable_out, 3) |-> pulse_output_one_n)
    else $error("disabled pin went low");
  a_disable_no_flag: assert property (cfg_one.disable_out &&
    $past(cfg_one.disable_out, 3) && !$past(status.pulse_ready_one) |-> !status.pulse_ready_one)
    else $error("disabled ready flag");
  a_read_clear_high: assert property (energy_high_read && read_clear_enable |=>
    energy_ready || energy_high_word == 32'h0)
    else $error("high word kept");
  a_read_keep_low: assert property (energy_high_read && read_clear_enable |=>
    energy_ready || $stable(energy_low_word))
    else $error("low word moved");
  a_timer_width: assert property ($rose(pulse_output_one_n) &&
    cfg_one.width_source && !cfg_one.disable_out && no_load == 3'h0 |->
    low_cnt == 32'(pulse_width_timer) * 32'h6)
    else $error("pulse width wrong");
endmodule

bind energy_pulse_and_power_accum energy_pulse_checker #(.SAMPLE_DIV(SAMPLE_DIV))
  energy_pulse_checker_i (
  .clk(clk), .rstn(rstn), .energy_power_enable(energy_power_enable),
  .power_interval_count(power_interval_count), .energy_high_read(energy_high_read),
  .read_clear_enable(read_clear_enable), .pulse_width_timer(pulse_width_timer),
  .cfg_one(cfg_one), .no_load(no_load), .pulse_output_one_n(pulse_output_one_n),
  .energy_high_word(energy_high_word), .energy_low_word(energy_low_word),
  .energy_ready(energy_ready), .power_ready(power_ready),
  .active_power_accum(active_power_accum), .reactive_power_accum(reactive_power_accum),
  .active_power_sign(active_power_sign), .reactive_power_sign(reactive_power_sign),
  .status(status)
);

//--- bench/pulse_counter.sv
// meter counter on one active-low pin
// assumes the pin is a registered output on clk
module pulse_counter (
  input wire logic clk, // sampling clock
  input wire logic pulse_n, // active-low pulse pin
  output int count // falling edges seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_n = 1'b1;
  initial count = 0;
  always @(posedge clk) begin
    last_n <= pulse_n;
    if (last_n === 1'b1 && pulse_n === 1'b0) begin
      count <= count + 1;
    end
  end
endmodule

//--- bench/energy_pulse_and_power_accum_test.sv
// self-checking bench for the back end
// assumes a short sample divider so the run stays brief
module energy_pulse_and_power_accum_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  energy_pulse_pkg::power_samples_type samples = '0;
  logic [2:0] no_load = 3'h0;
  logic half_cycle = 1'b0;
  logic energy_overwrite_select = 1'b0;
  logic energy_interval_source = 1'b0;
  logic read_clear_enable = 1'b0;
  logic energy_power_enable = 1'b0;
  logic [12:0] energy_interval_count = 13'h0;
  logic [12:0] power_interval_count = 13'h0;
  logic energy_high_read = 1'b0;
  logic [31:0] pulse_threshold = 32'h0010_0000;
  logic [18:0] pulse_width_timer = 19'h5;
  energy_pulse_pkg::pulse_config_type cfg_one = '0;
  energy_pulse_pkg::pulse_config_type cfg_two = '0;
  logic pulse_accum_clear = 1'b0;
  energy_pulse_pkg::status_type status_clear = '0;
  logic pin_one_n, pin_two_n, energy_ready, power_ready;
  logic [31:0] energy_high_word, active_power_accum, reactive_power_accum, apparent_power_accum;
  logic [12:0] energy_low_word;
  wire [95:0] power_words = {active_power_accum, reactive_power_accum, apparent_power_accum};
  wire [44:0] energy_words = {energy_high_word, energy_low_word};
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int cnt_one, cnt_two;
  logic [95:0] power_q[$];
  logic [44:0] energy_q[$];

  energy_pulse_and_power_accum #(.SAMPLE_DIV(50), .FIXED_CYCLES(200))
    energy_pulse_and_power_accum_i (
    .clk(clk), .rstn(rstn), .samples(samples), .no_load(no_load), .half_cycle(half_cycle),
    .energy_overwrite_select(energy_overwrite_select),
    .energy_interval_source(energy_interval_source), .read_clear_enable(read_clear_enable),
    .energy_power_enable(energy_power_enable), .energy_interval_count(energy_interval_count),
    .power_interval_count(power_interval_count), .energy_high_read(energy_high_read),
    .pulse_threshold(pulse_threshold), .pulse_width_timer(pulse_width_timer),
    .cfg_one(cfg_one), .cfg_two(cfg_two), .pulse_accum_clear(pulse_accum_clear),
    .status_clear(status_clear), .pulse_output_one_n(pin_one_n), .pulse_output_two_n(pin_two_n),
    .energy_high_word(energy_high_word), .energy_low_word(energy_low_word),
    .energy_ready(energy_ready), .power_ready(power_ready),
    .active_power_accum(active_power_accum), .reactive_power_accum(reactive_power_accum),
    .apparent_power_accum(apparent_power_accum), .active_power_sign(),
    .reactive_power_sign(), .pulse_sign_one(), .pulse_sign_two(), .status()
  );
  pulse_counter counter_one_i (.clk(clk), .pulse_n(pin_one_n), .count(cnt_one));
  pulse_counter counter_two_i (.clk(clk), .pulse_n(pin_two_n), .count(cnt_two));

  initial begin
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic note(logic ok, string what);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("unexpected %s at %0t", what, $time);
    end
  endtask
  task automatic check_power(logic [95:0] got, logic [95:0] exp);
    note(got === exp, "power sums");
  endtask
  task automatic check_energy(logic [44:0] got, logic [44:0] exp);
    note(got === exp, "energy words");
  endtask
  task automatic check_count(int got, int exp);
    note(got <= exp + 2 && got >= exp - 2, "pulse count");
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] pacc(logic signed [31:0] s, int n);
    return 32'((42'(s) * n) >>> 13);
  endfunction
  function automatic logic [44:0] eacc(logic signed [31:0] s, int n);
    return 45'(45'(s) * n);
  endfunction
  function automatic int rate(logic [31:0] p, int d);
    return int'(819.2 * p / (real'(pulse_threshold) * 512.0 * d));
  endfunction
  // returns on the edge after a ready, so pushes never race the watcher
  task automatic sync(ref logic flag);
    do @(negedge clk); while (flag !== 1'b1);
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (power_ready === 1'b1 && power_q.size() > 0) begin
      check_power(power_words, power_q.pop_front());
    end
    if (energy_ready === 1'b1 && energy_q.size() > 0) begin
      check_energy(energy_words, energy_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    half_cycle <= energy_interval_source && (cycles % 100 == 7);
    if (cycles == 60000) begin
      note(1'b0, "timeout");
      tally_and_finish();
    end
  end
  initial begin
    energy_pulse_pkg::power_samples_type s;
    int n, d1, c1, c2;
    logic signed [31:0] a;
    logic [44:0] e;
    void'($urandom(32'h0f28));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    energy_power_enable <= 1'b1;
    // change interval only just after a ready
    repeat (6) begin
      sync(power_ready);
      n = $urandom_range(4, 1);
      power_interval_count <= 13'(n);
      s.active = 32'($signed($urandom) >>> 6);
      s.reactive = 32'($signed($urandom) >>> 6);
      s.apparent = 32'($urandom >> 7);
      samples <= s;
      power_q.push_back({pacc(s.active, n + 1), pacc(s.reactive, n + 1),
                         pacc(s.apparent, n + 1)});
    end
    sync(power_ready);
    a = 32'($signed($urandom) >>> 12);
    s = '0;
    s.active = a;
    samples <= s;
    energy_interval_count <= 13'h2;
    energy_overwrite_select <= 1'b1;
    sync(energy_ready);
    sync(energy_ready);
    energy_q.push_back(eacc(a, 3));
    sync(energy_ready);
    energy_overwrite_select <= 1'b0;
    energy_q.push_back(eacc(a, 6));
    sync(energy_ready);
    e = eacc(a, 9);
    energy_q.push_back(e);
    sync(energy_ready);
    read_clear_enable <= 1'b1;
    energy_high_read <= 1'b1;
    @(posedge clk);
    energy_high_read <= 1'b0;
    @(negedge clk);
    check_energy(energy_words, {32'h0, e[12:0]});
    energy_q.push_back({32'h0, e[12:0]} + eacc(a, 3));
    sync(energy_ready);
    energy_interval_source <= 1'b1;
    energy_overwrite_select <= 1'b1;
    read_clear_enable <= 1'b0;
    sync(energy_ready);
    energy_q.push_back(eacc(a, 6));
    sync(energy_ready);
    s.active = 32'($urandom_range(32'h1000_0000, 32'h0800_0000));
    s.reactive = 32'($urandom_range(32'h1000_0000, 32'h0800_0000));
    samples <= s;
    d1 = 2 * $urandom_range(3, 1);
    cfg_one <= '{3'h0, 3'h7, 16'(d1), 1'b1, 1'b0};
    cfg_two <= '{3'h1, 3'h7, 16'(d1 + 1), 1'b0, 1'b0};
    pulse_accum_clear <= 1'b1;
    @(posedge clk);
    pulse_accum_clear <= 1'b0;
    repeat (2000) @(posedge clk);
    c1 = cnt_one;
    c2 = cnt_two;
    repeat (20000) @(posedge clk);
    check_count(cnt_one - c1, rate(s.active, d1));
    check_count(cnt_two - c2, rate(s.reactive, d1 + 1));
    cfg_one.disable_out <= 1'b1;
    repeat (5) @(posedge clk);
    c1 = cnt_one;
    c2 = cnt_two;
    repeat (20000) @(posedge clk);
    check_count(cnt_one - c1, 0);
    check_count(cnt_two - c2, rate(s.reactive, d1 + 1));
    tally_and_finish();
  end
endmodule
